// ### core/pin_func_decode.sv
// Function decoder for one port pin
`timescale 1ns/10ps
module pin_func_decode (
  input wire logic dir,
  input wire logic sel,
  input wire logic aen,
  output pin_mux_pkg::pin_func_e func
);
  always_comb begin
    if (aen) begin
      func = pin_mux_pkg::fn_analog;
    end else if (!sel) begin
      func = pin_mux_pkg::fn_gpio;
    end else if (dir) begin
      func = pin_mux_pkg::fn_drive_low;
    end else begin
      func = pin_mux_pkg::fn_periph_in;
    end
  end
endmodule

// ### core/pin_mux_cfg.svh
// Constants for the upper port pin function multiplexer
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH
`define PIN_COUNT 2
`define PIN6_IDX 0
`define PIN7_IDX 1
`define PIN6_ANALOG_EN_BIT 7
`define PIN_DIR_RESET 2'h0
`define PIN_SEL_RESET 2'h0
`define ANALOG_EN_RESET 8'h00
`endif

// ### core/pin_mux_pkg.sv
// Types for the upper port pin function multiplexer
package pin_mux_pkg;
  typedef enum logic [1:0] {
    fn_gpio,
    fn_periph_in,
    fn_drive_low,
    fn_analog
  } pin_func_e;

  typedef struct packed {
    logic [1:0] port4_direction_bits;
    logic [1:0] port4_peripheral_select_bits;
    logic [7:0] analog_enable_upper_bits;
  } pin_ctrl_s;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } pin_drive_s;
endpackage

// ### core/port4_upper_pin_function_mux.sv
// Pin function multiplexer for port bits 6 and 7 of the fourth port
`timescale 1ns/10ps
`include "pin_mux_cfg.svh"

// Functional notes
// - After reset both pins are plain I/O, select and analog enable cleared.
// - Select 0, analog 0: direction 0 input via Schmitt, 1 output.
// - Analog enable set: driver and Schmitt off, pin goes to analog.
// - Bit 6: select 1 dir 0 feeds timer hiz control; dir 1 drives low.
// - Bit 7: select 1 dir 0 feeds timer clock; dir 1 drives low; no analog.
module port4_upper_pin_function_mux (
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrl_we,
  input wire pin_mux_pkg::pin_ctrl_s ctrl_wdata,
  input wire logic [1:0] port_out_bits,
  input wire logic [1:0] pin_in,
  output pin_mux_pkg::pin_ctrl_s ctrl_q,
  output logic [1:0] pin_out_q,
  output logic [1:0] pin_oe_q,
  output logic [1:0] port_in_q,
  output logic timer_output_hiz_control_in_q,
  output logic timer_external_clock_in_q,
  output logic analog_channel_fifteen_en_q,
  output logic [1:0] schmitt_en_q
);
  ////////////////////////////////////////////////////////////////////////////
  pin_mux_pkg::pin_func_e func [`PIN_COUNT];
  logic [1:0] aen;
  logic [1:0] out_d;
  logic [1:0] oe_d;
  logic [1:0] schmitt_d;

  // Bit 7 has no analog path, so its enable is tied off
  assign aen[`PIN6_IDX] = ctrl_q.analog_enable_upper_bits[`PIN6_ANALOG_EN_BIT];
  assign aen[`PIN7_IDX] = 1'b0;

  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i++) begin : g_pin
      pin_func_decode u_dec (
        .dir(ctrl_q.port4_direction_bits[i]),
        .sel(ctrl_q.port4_peripheral_select_bits[i]),
        .aen(aen[i]),
        .func(func[i])
      );
      always_comb begin
        out_d[i] = 1'b0;
        oe_d[i] = 1'b0;
        schmitt_d[i] = 1'b1;
        case (func[i])
          pin_mux_pkg::fn_gpio: begin
            out_d[i] = port_out_bits[i];
            oe_d[i] = ctrl_q.port4_direction_bits[i];
          end
          pin_mux_pkg::fn_drive_low: begin
            out_d[i] = 1'b0;
            oe_d[i] = 1'b1;
          end
          pin_mux_pkg::fn_analog: begin
            schmitt_d[i] = 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Control register, loaded by the CPU
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q.port4_direction_bits <= `PIN_DIR_RESET;
      ctrl_q.port4_peripheral_select_bits <= `PIN_SEL_RESET;
      ctrl_q.analog_enable_upper_bits <= `ANALOG_EN_RESET;
    end else if (ctrl_we) begin
      ctrl_q <= ctrl_wdata;
    end
  end

  // Pad drive, registered so outputs come from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out_q <= 2'h0;
      pin_oe_q <= 2'h0;
      schmitt_en_q <= 2'h3;
      analog_channel_fifteen_en_q <= 1'b0;
    end else begin
      pin_out_q <= out_d;
      pin_oe_q <= oe_d;
      schmitt_en_q <= schmitt_d;
      analog_channel_fifteen_en_q <= aen[`PIN6_IDX];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input path; gating by Schmitt enable avoids floating analog levels
  logic [1:0] gated_in;
  assign gated_in = pin_in & schmitt_d;

  always_ff @(posedge clk) begin
    if (rst) begin
      port_in_q <= 2'h0;
    end else begin
      port_in_q <= gated_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_output_hiz_control_in_q <= 1'b0;
      timer_external_clock_in_q <= 1'b0;
    end else begin
      timer_output_hiz_control_in_q <=
        (func[`PIN6_IDX] == pin_mux_pkg::fn_periph_in) & gated_in[`PIN6_IDX];
      timer_external_clock_in_q <=
        (func[`PIN7_IDX] == pin_mux_pkg::fn_periph_in) & gated_in[`PIN7_IDX];
    end
  end
endmodule

// ### verification/board_pins.sv
// Board model for the two upper port pads
`timescale 1ns/10ps
module board_pins (
  input logic [1:0] out,
  input logic [1:0] oe,
  input logic [1:0] ext,
  output logic [1:0] pin_in
);
  // Device driver wins where enabled, else the board level shows
  assign pin_in = (oe & out) | (~oe & ext);
endmodule

// ### verification/pin_mux_chk.sv
// Assertions on the upper port pin function mux
`timescale 1ns/10ps
module pin_mux_chk (
  input logic clk,
  input logic rst,
  input pin_mux_pkg::pin_ctrl_s ctrl_q,
  input logic [1:0] pin_in,
  input logic [1:0] pin_out_q,
  input logic [1:0] pin_oe_q,
  input logic [1:0] port_in_q,
  input logic [1:0] schmitt_en_q,
  input logic timer_output_hiz_control_in_q,
  input logic timer_external_clock_in_q
);
  wire [1:0] d = ctrl_q.port4_direction_bits;
  wire [1:0] s = ctrl_q.port4_peripheral_select_bits;
  wire a = ctrl_q.analog_enable_upper_bits[7];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_plain_io: assert property ($fell(rst) |-> ctrl_q == '0 && pin_oe_q == 2'h0)
    else $error("Not plain I/O after reset");
  a_gpio_dir: assert property (!s[1] |=> pin_oe_q[1] == $past(d[1])) else $error("Dir");
  a_analog_off: assert property (a |=> !pin_oe_q[0] && !schmitt_en_q[0] && !port_in_q[0])
    else $error("Analog pin not isolated");
  a_drive_low: assert property (s[1] && d[1] |=> pin_oe_q[1] && !pin_out_q[1])
    else $error("Pin 7 not driven low");
  a_hiz_feed: assert property (s[0] && !d[0] && !a |=>
    timer_output_hiz_control_in_q == $past(pin_in[0])) else $error("Hiz input");
  a_clock_feed: assert property (s[1] && !d[1] |=>
    timer_external_clock_in_q == $past(pin_in[1])) else $error("Clock input");
  c_analog: cover property (a);
  c_low: cover property (s[1] && d[1]);
  c_clk: cover property (s[1] && !d[1]);
endmodule
bind port4_upper_pin_function_mux pin_mux_chk pin_mux_chk_inst (.*);

// ### verification/port4_upper_pin_function_mux_tb.sv
// Testbench for the upper port pin function mux
`timescale 1ns/10ps
module port4_upper_pin_function_mux_tb;
  logic clk = 1'h0, rst = 1'h1, ctrl_we = 1'h0;
  logic [1:0] port_out_bits = 2'h0, ext = 2'h0, pin_in, pin_out_q, pin_oe_q, port_in_q;
  logic [1:0] schmitt_en_q;
  logic timer_output_hiz_control_in_q, timer_external_clock_in_q, analog_channel_fifteen_en_q;
  pin_mux_pkg::pin_ctrl_s ctrl_wdata = '0, ctrl_q;
  int n_fail = 0, n_compared = 0;
  always #10 clk = ~clk;
  port4_upper_pin_function_mux port4_upper_pin_function_mux_inst (.*);
  board_pins board_pins_inst (.out(pin_out_q), .oe(pin_oe_q), .ext(ext), .pin_in(pin_in));
  task wrap_up;
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task cmp(input logic [3:0] g, input logic [3:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Control word, port data and board level in one go; waits out the pad latency
  task wr(input logic [15:0] v);
    {ctrl_wdata, port_out_bits, ext} = v;
    ctrl_we = 1'h1;
    @(negedge clk) ctrl_we = 1'h0;
    repeat (3) @(negedge clk);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'h0;
    cmp({schmitt_en_q, pin_oe_q}, 4'hc);
    wr(16'h800d); // Pin 7 output high, pin 6 input high
    cmp({pin_oe_q, pin_out_q}, 4'hb);
    cmp({port_in_q, timer_output_hiz_control_in_q, timer_external_clock_in_q}, 4'hc);
    wr(16'hf00c);
    cmp({pin_oe_q, pin_out_q}, 4'hc);
    wr(16'h3001);
    cmp({pin_oe_q, timer_output_hiz_control_in_q, timer_external_clock_in_q}, 4'h2);
    wr(16'h3002);
    cmp({pin_oe_q, timer_output_hiz_control_in_q, timer_external_clock_in_q}, 4'h1);
    wr(16'h5805); // Analog on pin 6 while asking for drive low
    cmp({pin_oe_q[0], schmitt_en_q[0], port_in_q[0], analog_channel_fifteen_en_q}, 4'h1);
    cmp(ctrl_q[7:4], 4'h8);
    cmp({schmitt_en_q, pin_oe_q}, 4'h8);
    wrap_up;
  end
  initial begin
    #5000 n_fail++;
    wrap_up;
  end
endmodule
